// >>> src/usb_dbg_pkg.sv
package usb_dbg_pkg;

	localparam int NPORT = 2;
	localparam int PW    = $clog2(NPORT);

	localparam logic [15:0] OFF_QSPACE = 16'hC160;
	localparam logic [15:0] OFF_LTDBG  = 16'hC164;
	localparam logic [15:0] OFF_LANE   = 16'hC168;
	localparam logic [15:0] OFF_BMU    = 16'hC16C;
	localparam logic [15:0] OFF_MUX    = 16'hC170;
	localparam logic [15:0] OFF_LSP    = 16'hC174;
	localparam logic [15:0] OFF_EP0    = 16'hC178;
	localparam logic [15:0] OFF_EP1    = 16'hC17C;
	localparam logic [15:0] OFF_HSMAP  = 16'hC180;
	localparam logic [15:0] OFF_FSMAP  = 16'hC188;
	localparam logic [15:0] OFF_PHYCFG = 16'hC200;

	localparam logic [31:0] PHYCFG_RST = 32'h4010_2400;
	localparam logic [31:0] MUX_RST    = 32'h003F_0000;
	localparam logic [31:0] EP1_RST    = 32'h0080_0000;
	localparam logic [5:0]  TRACE_OFF  = 6'h3F;

	localparam logic [2:0] P3C_RUN      = 3'h0;
	localparam logic [2:0] P3C_ENTRY    = 3'h1;
	localparam logic [2:0] P3C_WAIT_IN  = 3'h2;
	localparam logic [2:0] P3C_STOP     = 3'h3;
	localparam logic [2:0] P3C_EXIT     = 3'h4;
	localparam logic [2:0] P3C_WAIT_OUT = 3'h5;

	localparam int  CLK_PERIOD_PS = 5000;
	localparam real XCVR_DLY_US   = 2.5;
	localparam int  XCVR_DLY_CYC  = int'($floor(XCVR_DLY_US * 1.0e6 / CLK_PERIOD_PS));
	localparam real LS_RATE_MBPS  = 1.5;
	localparam int  LS_HALF_CYC   = int'($ceil(1.0e6 / (2.0 * LS_RATE_MBPS) / CLK_PERIOD_PS));
	localparam logic [3:0] GAP_BASE_HALVES = 4'h4;

	typedef enum logic [2:0] {
		state_clock_running,
		state_deep_sleep_entry_request,
		state_wait_entry_status,
		state_deep_sleep_clock_stopped,
		state_deep_sleep_exit_request,
		state_wait_exit_status
	} p3_state_t;

	typedef struct packed {
		logic       rx_equaliser_training_mirror;
		logic [1:0] tx_deemphasis_mirror;
		logic       tx_swing_mirror;
		logic       rx_termination_mirror;
		logic       tx_ones_zeros_mirror;
	} pipe_mirror_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [15:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} apb_rsp_t;

	typedef struct packed {
		logic       utmi_phy_soft_reset;
		logic       free_running_phy_clock_present;
		logic [4:0] rsv_a;
		logic [2:0] low_speed_turnaround_gap;
		logic [2:0] low_speed_interpacket_gap;
		logic [4:0] rsv_b;
		logic [3:0] fifo_turnaround_clocks;
		logic       chirp_transceiver_delay;
		logic [8:0] rsv_c;
	} phycfg_t;

	typedef struct packed {
		logic [7:0] rsv_a;
		logic [7:0] trace_sel;
		logic       debug_capability_trace_enable;
		logic       rsv_b;
		logic [5:0] host_trace_select;
		logic [3:0] device_trace_select;
		logic [3:0] endpoint_trace_select;
	} mux_t;

	typedef struct packed {
		p3_state_t [NPORT-1:0] p3;
		logic [8:0]  qsel;
		logic [23:0] buffer_control_debug;
		mux_t        mux;
		logic [3:0]  hs_inst;
		logic [3:0]  fs_inst;
		phycfg_t     phy;
		logic [31:0] list_processor;
		logic [31:0] ep0;
		logic [31:0] ep1;
		logic [31:0] trace;
		logic [31:0] prdata;
		logic        pslverr;
		logic        ulpi_req;
		logic        chirp_on;
		logic [9:0]  gap_cnt;
		logic [8:0]  chirp_cnt;
	} state_t;

endpackage

// >>> src/usb_dbg_regs.sv
`timescale 1ns/1ps
`default_nettype none

module usb_dbg_regs (
	input  wire logic                                   CLK_I,
	input  wire logic                                   RSTN_I,
	input  wire logic                                   CE_I,
	input  wire usb_dbg_pkg::apb_req_t                  APB_REQ_I,
	output var  usb_dbg_pkg::apb_rsp_t                  APB_RSP_O,
	input  wire logic                                   HOST_MODE_I,
	input  wire logic                                   USB2_ONLY_I,
	input  wire logic                                   ULPI_SEL_I,
	input  wire logic                                   DEVICE_ONLY_I,
	input  wire logic                                   CORE_SOFT_RESET_I,
	input  wire logic                                   ULPI_RESET_DONE_I,
	input  wire usb_dbg_pkg::pipe_mirror_t [usb_dbg_pkg::NPORT-1:0] PIPE_MIRROR_I,
	input  wire logic [usb_dbg_pkg::NPORT-1:0]          P3_REQUEST_I,
	input  wire logic [usb_dbg_pkg::NPORT-1:0]          PHY_STATUS_I,
	input  wire logic [usb_dbg_pkg::NPORT-1:0][8:0]     LANE_BIT_ERROR_I,
	input  wire logic [15:0]                            SPACE_AVAIL_I,
	input  wire logic [3:0]                             BUF_DATA_DBG_I,
	input  wire logic [3:0]                             BUF_CACHE_DBG_I,
	input  wire logic [31:0]                            LSP_DEBUG_I,
	input  wire logic [63:0]                            EP_DEBUG_I,
	input  wire logic                                   LS_RX_END_I,
	input  wire logic                                   LS_TX_END_I,
	input  wire logic                                   CHIRP_REQ_I,
	output logic                                        HS_PHY_RESET_O,
	output logic                                        ULPI_FUNC_RESET_O,
	output logic                                        HS_MAC_CLOCK_FROM_PORT0_O,
	output logic                                        LS_TX_READY_O,
	output logic [3:0]                                  FIFO_TURNAROUND_O,
	output logic                                        CHIRP_TXVALID_O,
	output logic [13:0]                                 LSP_SELECT_O,
	output logic                                        DBC_TRACE_O,
	output logic [3:0]                                  EP_SELECT_O,
	output logic [31:0]                                 LA_TRACE_O,
	output logic [3:0]                                  PORT1_HS_INSTANCE_O,
	output logic [3:0]                                  PORT1_FS_INSTANCE_O
);
	import usb_dbg_pkg::*;

	state_t s;
	state_t next_s;

	logic              setup;
	logic              access;
	logic              wr;
	logic [PW-1:0]     pidx;
	logic              port_ok;
	logic [31:0]       lt_sel;
	logic [8:0]        lane_sel;
	logic [31:0]       rd;
	logic              hit;

	function automatic logic [2:0] p3_code(input p3_state_t st);
		case (st)
			state_clock_running:            p3_code = P3C_RUN;
			state_deep_sleep_entry_request: p3_code = P3C_ENTRY;
			state_wait_entry_status:        p3_code = P3C_WAIT_IN;
			state_deep_sleep_clock_stopped: p3_code = P3C_STOP;
			state_deep_sleep_exit_request:  p3_code = P3C_EXIT;
			state_wait_exit_status:         p3_code = P3C_WAIT_OUT;
			default:                        p3_code = P3C_RUN;
		endcase
	endfunction

	function automatic logic [31:0] lt_word(input pipe_mirror_t m, input p3_state_t st);
		lt_word = {23'h0, m.rx_equaliser_training_mirror, m.tx_deemphasis_mirror,
			p3_code(st), m.tx_swing_mirror, m.rx_termination_mirror,
			m.tx_ones_zeros_mirror};
	endfunction

	function automatic logic [9:0] gap_cycles(input logic [2:0] code);
		gap_cycles = 10'((GAP_BASE_HALVES + 4'(code)) * LS_HALF_CYC);
	endfunction

	assign setup  = APB_REQ_I.psel && !APB_REQ_I.penable;
	assign access = APB_REQ_I.psel && APB_REQ_I.penable;
	assign wr     = access && APB_REQ_I.pwrite;

	// port select lives in queue-space low bits
	assign pidx    = s.qsel[PW-1:0];
	assign port_ok = (s.qsel[3:0] < 4'(NPORT));

	// link-training view of the selected port
	// mirrors straight from the PIPE outputs
	assign lt_sel   = port_ok ? lt_word(PIPE_MIRROR_I[pidx], s.p3[pidx]) : 32'h0;
	// lane error count of the selected port
	assign lane_sel = port_ok ? LANE_BIT_ERROR_I[pidx] : 9'h0;

	// Read decode, pure function of state and inputs
	// a read alters no state but the registered prdata and pslverr
	always_comb begin
		rd  = 32'h0;
		hit = 1'b1;
		case (APB_REQ_I.paddr)
			OFF_QSPACE: rd = {SPACE_AVAIL_I, 7'h0, s.qsel};
			// nothing to report without a SuperSpeed link
			OFF_LTDBG:  rd = USB2_ONLY_I ? 32'h0 : lt_sel;
			OFF_LANE:   rd = {23'h0, lane_sel};
			OFF_BMU:    rd = {s.buffer_control_debug, BUF_DATA_DBG_I, BUF_CACHE_DBG_I};
			OFF_MUX:    rd = s.mux;
			OFF_LSP:    rd = s.list_processor;
			OFF_EP0:    rd = s.ep0;
			OFF_EP1:    rd = s.ep1;
			OFF_HSMAP:  rd = {28'h0, s.hs_inst};
			OFF_FSMAP:  rd = {28'h0, s.fs_inst};
			OFF_PHYCFG: rd = s.phy;
			default:    hit = 1'b0;
		endcase
	end

	always_comb begin
		next_s = s;

		if (setup) begin
			next_s.prdata  = rd;
			next_s.pslverr = !hit;
		end

		if (wr) begin
			case (APB_REQ_I.paddr)
				OFF_QSPACE: next_s.qsel = APB_REQ_I.pwdata[8:0];
				OFF_BMU:    next_s.buffer_control_debug = APB_REQ_I.pwdata[31:8];
				OFF_MUX: begin
					next_s.mux.trace_sel = APB_REQ_I.pwdata[23:16];
					next_s.mux.debug_capability_trace_enable = APB_REQ_I.pwdata[15];
					next_s.mux.host_trace_select = APB_REQ_I.pwdata[13:8];
					next_s.mux.device_trace_select = APB_REQ_I.pwdata[7:4];
					next_s.mux.endpoint_trace_select = APB_REQ_I.pwdata[3:0];
				end
				OFF_HSMAP:  next_s.hs_inst = APB_REQ_I.pwdata[3:0];
				OFF_FSMAP:  next_s.fs_inst = APB_REQ_I.pwdata[3:0];
				OFF_PHYCFG: begin
					next_s.phy.utmi_phy_soft_reset = APB_REQ_I.pwdata[31];
					// free clock cannot be claimed on a device-only core
					next_s.phy.free_running_phy_clock_present =
						APB_REQ_I.pwdata[30] && !DEVICE_ONLY_I;
					next_s.phy.low_speed_turnaround_gap = APB_REQ_I.pwdata[24:22];
					next_s.phy.low_speed_interpacket_gap = APB_REQ_I.pwdata[21:19];
					next_s.phy.fifo_turnaround_clocks = APB_REQ_I.pwdata[13:10];
					next_s.phy.chirp_transceiver_delay = APB_REQ_I.pwdata[9];
				end
				default: ;
			endcase
		end

		for (int i = 0; i < NPORT; i++) begin
			case (s.p3[i])
				state_clock_running:
					if (P3_REQUEST_I[i])
						next_s.p3[i] = state_deep_sleep_entry_request;
				state_deep_sleep_entry_request:
					next_s.p3[i] = state_wait_entry_status;
				state_wait_entry_status:
					if (PHY_STATUS_I[i])
						next_s.p3[i] = state_deep_sleep_clock_stopped;
				state_deep_sleep_clock_stopped:
					if (!P3_REQUEST_I[i])
						next_s.p3[i] = state_deep_sleep_exit_request;
				state_deep_sleep_exit_request:
					next_s.p3[i] = state_wait_exit_status;
				state_wait_exit_status:
					if (PHY_STATUS_I[i])
						next_s.p3[i] = state_clock_running;
				default:
					next_s.p3[i] = state_clock_running;
			endcase
		end

		// endpoint and list debug words captured live
		next_s.list_processor = LSP_DEBUG_I;
		next_s.ep0 = EP_DEBUG_I[31:0];
		next_s.ep1 = EP_DEBUG_I[63:32];

		// trace mux; only the low six select bits decode
		case (s.mux.trace_sel[5:0])
			TRACE_OFF: next_s.trace = 32'h0;
			6'h00:     next_s.trace = USB2_ONLY_I ? 32'h0 : lt_sel;
			6'h01:     next_s.trace = {23'h0, lane_sel};
			6'h02:     next_s.trace = s.list_processor;
			6'h03:     next_s.trace = s.ep0;
			6'h04:     next_s.trace = s.ep1;
			default:   next_s.trace = 32'h0;
		endcase

		// request a function-control reset; a new request beats completion
		if (ULPI_RESET_DONE_I)
			next_s.ulpi_req = 1'b0;
		if (CORE_SOFT_RESET_I)
			next_s.ulpi_req = 1'b1;

		if (s.gap_cnt != 10'h0)
			next_s.gap_cnt = s.gap_cnt - 10'h1;
		if (HOST_MODE_I) begin
			if (LS_RX_END_I)
				next_s.gap_cnt = gap_cycles(s.phy.low_speed_turnaround_gap);
			if (LS_TX_END_I)
				next_s.gap_cnt = gap_cycles(s.phy.low_speed_interpacket_gap);
		end else begin
			next_s.gap_cnt = 10'h0;
		end

		// chirp delay after selecting the HS transceiver
		if (!CHIRP_REQ_I) begin
			next_s.chirp_on  = 1'b0;
			next_s.chirp_cnt = 9'h0;
		end else if (!s.chirp_on) begin
			next_s.chirp_on  = 1'b1;
			next_s.chirp_cnt = (s.phy.chirp_transceiver_delay && !HOST_MODE_I) ?
				9'(XCVR_DLY_CYC) : 9'h0;
		end else if (s.chirp_cnt != 9'h0) begin
			next_s.chirp_cnt = s.chirp_cnt - 9'h1;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			s          <= '0;
			s.phy      <= PHYCFG_RST;
			s.mux      <= MUX_RST;
			s.ep1      <= EP1_RST;
			s.ulpi_req <= 1'b1;
		end else if (CE_I) begin
			s <= next_s;
		end
	end

	// Zero-wait slave: one driver for the whole response
	assign APB_RSP_O = '{pready: 1'b1, prdata: s.prdata, pslverr: s.pslverr};

	// UTMI reset follows the soft-reset bit while ULPI is not selected
	assign HS_PHY_RESET_O            = s.phy.utmi_phy_soft_reset && !ULPI_SEL_I;
	assign ULPI_FUNC_RESET_O         = s.ulpi_req && ULPI_SEL_I;
	// MAC clock taken from port-0 free clock
	assign HS_MAC_CLOCK_FROM_PORT0_O = s.phy.free_running_phy_clock_present;
	assign LS_TX_READY_O             = (s.gap_cnt == 10'h0);
	assign FIFO_TURNAROUND_O = HOST_MODE_I ? 4'h0 : s.phy.fifo_turnaround_clocks;
	assign CHIRP_TXVALID_O   = CHIRP_REQ_I && s.chirp_on && (s.chirp_cnt == 9'h0);
	// host uses all three fields, device only its own
	assign LSP_SELECT_O = HOST_MODE_I ?
		{s.mux.host_trace_select, s.mux.device_trace_select, s.mux.endpoint_trace_select} :
		{10'h0, s.mux.device_trace_select};
	assign EP_SELECT_O  = HOST_MODE_I ? 4'h0 : s.mux.endpoint_trace_select;
	// debug-capability list data only in host mode
	assign DBC_TRACE_O  = HOST_MODE_I && s.mux.debug_capability_trace_enable;
	assign LA_TRACE_O   = s.trace;
	assign PORT1_HS_INSTANCE_O = s.hs_inst;
	assign PORT1_FS_INSTANCE_O = s.fs_inst;

	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);

	logic [31:0] lt_port0;
	assign lt_port0 = lt_word(PIPE_MIRROR_I[0], s.p3[0]);

	sequence s_chirp_start;
		CE_I && CHIRP_REQ_I && !s.chirp_on && s.phy.chirp_transceiver_delay && !HOST_MODE_I;
	endsequence

	sequence s_chirp_held;
		CHIRP_REQ_I [*8];
	endsequence

	a_p3_entry_step: assert property (
		(CE_I && s.p3[0] == state_clock_running && P3_REQUEST_I[0]) |=>
		p3_code(s.p3[0]) == P3C_ENTRY)
		else $error("P3 entry request not reported");

	a_lt_port_pick: assert property (
		(CE_I && setup && APB_REQ_I.paddr == OFF_LTDBG && !USB2_ONLY_I &&
		s.qsel[3:0] == 4'h0) |=> APB_RSP_O.prdata == $past(lt_port0))
		else $error("Link-training read not from selected port");

	a_lt_usb2_blank: assert property (
		(CE_I && setup && APB_REQ_I.paddr == OFF_LTDBG && USB2_ONLY_I) |=>
		APB_RSP_O.prdata == 32'h0)
		else $error("Link-training read not empty in USB2-only mode");

	a_lane_upper_zero: assert property (
		(CE_I && setup && APB_REQ_I.paddr == OFF_LANE) |=> APB_RSP_O.prdata[31:9] == 23'h0)
		else $error("Lane error upper bits not zero");

	a_trace_off_zero: assert property (
		(CE_I && s.mux.trace_sel[5:0] == TRACE_OFF) |=> LA_TRACE_O == 32'h0)
		else $error("Trace not zero with off select");

	a_map_reserved: assert property (
		(CE_I && setup && APB_REQ_I.paddr == OFF_HSMAP) |=> APB_RSP_O.prdata[31:4] == 28'h0)
		else $error("Instance map reserved bits not zero");

	a_utmi_reset_set: assert property (
		(CE_I && wr && APB_REQ_I.paddr == OFF_PHYCFG && APB_REQ_I.pwdata[31] && !ULPI_SEL_I)
		|=> HS_PHY_RESET_O)
		else $error("UTMI reset not raised by soft-reset bit");

	a_ulpi_reset_req: assert property (
		(CE_I && CORE_SOFT_RESET_I && ULPI_SEL_I) |=> ULPI_FUNC_RESET_O)
		else $error("ULPI function reset not requested");

	a_gap_blocks_tx: assert property (
		(CE_I && HOST_MODE_I && LS_TX_END_I) |=> !LS_TX_READY_O [*2])
		else $error("LS gap not started after transmit");

	a_chirp_delayed: assert property (
		s_chirp_start ##1 s_chirp_held |-> !CHIRP_TXVALID_O)
		else $error("Chirp transmit valid before transceiver delay");

endmodule

`default_nettype wire

// >>> bench/usb_phy_model.sv
`timescale 1ns/1ps
`default_nettype none
module usb_phy_model (
	input  wire logic                        clk_i,
	input  wire logic                        rstn_i,
	input  wire logic [usb_dbg_pkg::NPORT-1:0] p3_request_i,
	input  wire logic [7:0]                  delay_i,
	output logic [usb_dbg_pkg::NPORT-1:0]    phy_status_o
);
	import usb_dbg_pkg::*;

	logic [NPORT-1:0]      last;
	logic [NPORT-1:0][7:0] cnt;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			last         <= '0;
			cnt          <= '0;
			phy_status_o <= '0;
		end else begin
			for (int p = 0; p < NPORT; p++) begin
				phy_status_o[p] <= (cnt[p] == 8'h01);
				if (p3_request_i[p] != last[p]) begin
					last[p] <= p3_request_i[p];
					cnt[p]  <= delay_i;
				end else if (cnt[p] != 8'h00) begin
					cnt[p] <= cnt[p] - 8'h01;
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> bench/usb_dbg_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module usb_dbg_regs_bench;
	import usb_dbg_pkg::*;

	logic                     clk, rstn, host, u2only, ulpi, devonly, csr, udone, er, ce;
	logic                     lsrx, lstx, chirp, hsrst, ufr, mclk, lsrdy, ctv, dbc;
	apb_req_t                 req;
	apb_rsp_t                 rsp;
	pipe_mirror_t [NPORT-1:0] pm;
	logic [NPORT-1:0]         p3req, phystat;
	logic [NPORT-1:0][8:0]    lane;
	logic [15:0]              space;
	logic [3:0]               bd, bc, fta, eps, hsi, fsi;
	logic [31:0]              list_processor, trace, rd, w;
	logic [63:0]              ep;
	logic [13:0]              lsel;
	logic [7:0]               dly;
	int                       n_mismatch, tests_run, n;
	logic [15:0]              ra [5];
	logic [31:0]              rm [5];
	logic [31:0]              rv [5];

	usb_dbg_regs DUT (.CLK_I(clk), .RSTN_I(rstn), .CE_I(ce), .APB_REQ_I(req),
		.APB_RSP_O(rsp), .HOST_MODE_I(host), .USB2_ONLY_I(u2only), .ULPI_SEL_I(ulpi),
		.DEVICE_ONLY_I(devonly), .CORE_SOFT_RESET_I(csr), .ULPI_RESET_DONE_I(udone),
		.PIPE_MIRROR_I(pm), .P3_REQUEST_I(p3req), .PHY_STATUS_I(phystat),
		.LANE_BIT_ERROR_I(lane), .SPACE_AVAIL_I(space), .BUF_DATA_DBG_I(bd),
		.BUF_CACHE_DBG_I(bc), .LSP_DEBUG_I(list_processor), .EP_DEBUG_I(ep), .LS_RX_END_I(lsrx),
		.LS_TX_END_I(lstx), .CHIRP_REQ_I(chirp), .HS_PHY_RESET_O(hsrst),
		.ULPI_FUNC_RESET_O(ufr), .HS_MAC_CLOCK_FROM_PORT0_O(mclk), .LS_TX_READY_O(lsrdy),
		.FIFO_TURNAROUND_O(fta), .CHIRP_TXVALID_O(ctv), .LSP_SELECT_O(lsel),
		.DBC_TRACE_O(dbc), .EP_SELECT_O(eps), .LA_TRACE_O(trace),
		.PORT1_HS_INSTANCE_O(hsi), .PORT1_FS_INSTANCE_O(fsi));

	usb_phy_model phy (.clk_i(clk), .rstn_i(rstn), .p3_request_i(p3req), .delay_i(dly),
		.phy_status_o(phystat));

	always #2.5 clk = ~clk;

	task automatic end_of_test;
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	// Setup, then access held until pready is seen high
	task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge clk);
		req.penable <= 1'b1;
		@(posedge clk);
		while (rsp.pready !== 1'b1 && t < 100) begin
			@(posedge clk);
			t++;
		end
		if (t >= 100)
			n_mismatch++;
		rd = rsp.prdata;
		er = rsp.pslverr;
		req.psel    <= 1'b0;
		req.penable <= 1'b0;
	endtask

	function automatic logic [31:0] lt_word(input int p, input logic [2:0] st);
		return {23'h0, pm[p][5:3], st, pm[p][2:0]};
	endfunction

	task automatic lt(input int p, input logic [2:0] st, input int k);
		repeat (k) @(posedge clk);
		apb(1'b0, OFF_LTDBG, 32'h0);
		chk(rd, lt_word(p, st));
	endtask

	task automatic gap(input logic tx);
		@(posedge clk);
		if (tx)
			lstx <= 1'b1;
		else
			lsrx <= 1'b1;
		@(posedge clk);
		{lsrx, lstx} <= 2'b00;
		n = 0;
		#1;
		while (lsrdy !== 1'b1 && n < 2000) begin
			cyc(1);
			n++;
		end
	endtask

	task automatic chirp_run;
		@(posedge clk) chirp <= 1'b1;
		n = 0;
		#1;
		while (ctv !== 1'b1 && n < 2000) begin
			cyc(1);
			n++;
		end
		@(posedge clk) chirp <= 1'b0;
		cyc(1);
		chk(32'(ctv), 32'h0);
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		end_of_test();
	end

	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		ce = 1'b1;
		req = '0;
		{host, u2only, ulpi, devonly, csr, udone, lsrx, lstx, chirp} = '0;
		p3req = '0;
		dly = 8'h28;
		void'($urandom(32'h77D3));
		pm = 12'($urandom);
		lane = 18'($urandom);
		list_processor = $urandom;
		ep = {$urandom, $urandom};
		space = 16'($urandom);
		{bd, bc} = 8'($urandom);
		ra = '{OFF_PHYCFG, OFF_MUX, OFF_HSMAP, OFF_FSMAP, OFF_BMU};
		rm = '{32'hC1F83E00, 32'h00FFBFFF, 32'h0000000F, 32'h0000000F, 32'hFFFFFF00};
		rv = '{PHYCFG_RST, MUX_RST, 32'h0, 32'h0, {24'h0, bd, bc}};
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		cyc(1);
		chk(32'(mclk), 32'h1);
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, ra[i], 32'h0);
			chk(rd, rv[i]);
			w = $urandom;
			apb(1'b1, ra[i], w);
			apb(1'b0, ra[i], 32'h0);
			chk(rd, (w & rm[i]) | (rv[i] & ~rm[i]));
			if (i == 2) chk(32'(hsi), w & 32'hF);
			if (i == 3) chk(32'(fsi), w & 32'hF);
		end
		apb(1'b1, 16'hC184, 32'hFFFFFFFF);
		apb(1'b0, 16'hC184, 32'h0);
		chk({rd[30:0], er}, 32'h1);
		@(posedge clk) devonly <= 1'b1;
		apb(1'b1, OFF_PHYCFG, 32'hC0000000);
		@(posedge clk) devonly <= 1'b0;
		cyc(1);
		chk({31'h0, mclk}, 32'h0);
		chk(32'(hsrst), 32'h1);
		@(posedge clk) ulpi <= 1'b1;
		cyc(1);
		chk({30'h0, hsrst, ufr}, 32'h1);
		@(posedge clk) udone <= 1'b1;
		@(posedge clk) udone <= 1'b0;
		cyc(1);
		chk(32'(ufr), 32'h0);
		@(posedge clk) csr <= 1'b1;
		@(posedge clk) csr <= 1'b0;
		cyc(1);
		chk(32'(ufr), 32'h1);
		for (int p = 0; p < NPORT; p++) begin
			dly <= (p == 0) ? 8'h28 : 8'h03;
			apb(1'b1, OFF_QSPACE, 32'(p));
			apb(1'b0, OFF_QSPACE, 32'h0);
			chk(rd, {space, 16'(p)});
			apb(1'b0, OFF_LANE, 32'h0);
			chk(rd, {23'h0, lane[p]});
			@(posedge clk) p3req[p] <= 1'b1;
			lt(p, (p == 0) ? P3C_WAIT_IN : P3C_STOP, 6);
			lt(p, P3C_STOP, 60);
			@(posedge clk) p3req[p] <= 1'b0;
			lt(p, (p == 0) ? P3C_WAIT_OUT : P3C_RUN, 6);
			lt(p, P3C_RUN, 60);
		end
		@(posedge clk) u2only <= 1'b1;
		apb(1'b0, OFF_LTDBG, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, OFF_EP1, 32'h0);
		chk(rd, ep[63:32]);
		apb(1'b0, OFF_LSP, 32'h0);
		chk(rd, list_processor);
		apb(1'b1, OFF_MUX, 32'h00C30000);
		cyc(3);
		chk(trace, ep[31:0]);
		apb(1'b1, OFF_MUX, 32'h00FFAA5C);
		cyc(3);
		chk(trace, 32'h0);
		@(posedge clk) host <= 1'b1;
		cyc(1);
		chk(32'({dbc, eps, lsel}), 32'({1'b1, 4'h0, 6'h2A, 4'h5, 4'hC}));
		@(posedge clk) host <= 1'b0;
		cyc(1);
		chk(32'({dbc, eps, lsel}), 32'({1'b0, 4'hC, 10'h0, 4'h5}));
		for (int c = 0; c < 2; c++) begin
			apb(1'b1, OFF_PHYCFG, 32'h00101600 | (c ? 32'h01C00000 : 32'h0));
			@(posedge clk) host <= 1'b1;
			cyc(1);
			chk(32'(fta), 32'h0);
			gap(1'b0);
			chk(32'(n), 32'((4 + 7 * c) * LS_HALF_CYC));
			gap(1'b1);
			chk(32'(n), 32'((4 + 2) * LS_HALF_CYC));
			chirp_run();
			chk(32'(n <= 2), 32'h1);
			@(posedge clk) host <= 1'b0;
			cyc(1);
			chk(32'(fta), 32'h5);
			gap(1'b0);
			chk(32'(n), 32'h0);
			chirp_run();
			chk(32'(n >= 499 && n <= 502), 32'h1);
		end
		// Clock enable low must freeze the map register
		apb(1'b1, OFF_HSMAP, 32'h00000005);
		@(posedge clk) ce <= 1'b0;
		apb(1'b1, OFF_HSMAP, 32'h0000000A);
		@(posedge clk) ce <= 1'b1;
		apb(1'b0, OFF_HSMAP, 32'h0);
		chk(rd, 32'h5);
		chk(32'(hsi), 32'h5);
		end_of_test();
	end
endmodule
`default_nettype wire
